// File: hw/auto_reload_pwm_timer.sv
// Auto-reload PWM timer with capture and external load, APB slave
//
// Chosen here: the address map and register access over APB.
`timescale 1ns/1ps

// Notes on behaviour
// - Auto-reload: count prescaler ticks; overflow reloads counter and raises PWM output
// - Counter equal to compare value drives PWM output low
// - Overflow sets sticky overflow flag; interrupt request while its enable is set
// - Compare match sets sticky match flag; interrupt request while its enable is set
// - Software writes reload, then load and enable bits; counter copies reload, counts
// - Capture mode: active input edge copies counter to reload register, sets edge flag
// - Capture and external-load modes count freely; overflow/match drive output as usual
// - Capture-with-reset mode: capture also clears counter and prescaler
// - External-load mode: active edge copies reload register into counter, running or not
// - Every counter load clears the prescaler at the same time
// - Writing 06h to flag status clears only overflow, edge flag kept
// - Request arriving during another service stays pending until later
// - Mode bits 00,01,10,11 select auto-reload, capture, capture-reset, external load
// - Edge detect off when enable bit zero; polarity bit picks rising or falling
// - Writing zero clears a flag bit, writing one leaves it
// - PWM pin carries waveform only while PWM output enable is set
module auto_reload_pwm_timer
(
  // Clock and reset
  input  wire logic                         ref_clk_i,
  input  wire logic                         rstn_i,
  // APB slave
  input  wire logic                         psel_i,
  input  wire logic                         penable_i,
  input  wire logic                         pwrite_i,
  input  wire logic [timer_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic [timer_pkg::DATA_W-1:0] pwdata_i,
  output logic      [timer_pkg::DATA_W-1:0] prdata_o,
  output logic                              pready_o,
  output logic                              pslverr_o,
  // Timer pins
  input  wire logic                         timer_input_pin_i,
  output logic                              pwm_output_pin_o,
  // Interrupt requests
  output logic                              irq_overflow_o,
  output logic                              irq_match_o,
  output logic                              irq_edge_o
);
  import timer_pkg::*;

  typedef struct packed {
    logic [7:0]  counter_value;
    logic [6:0]  prescaler;
    logic        count_enable_bit;
    logic        pwm_output_enable;
    logic        edge_irq_enable;
    logic        match_irq_enable;
    logic        overflow_irq_enable;
    mode_e       mode;
    logic        edge_event_flag;
    logic        match_flag;
    logic        overflow_flag;
    logic [2:0]  prescale_select;
    logic        edge_polarity_select;
    logic        edge_detect_enable;
    logic [1:0]  clock_select;
    logic [7:0]  reload_capture;
    logic [7:0]  compare_value;
    logic        pwm_level;
    logic        pwm_pin;
    logic        irq_ovf;
    logic        irq_match;
    logic        irq_edge;
    logic [31:0] prdata;
  } timer_s;

  timer_s q;
  timer_s d;

  logic       div3_tick;
  logic       pin_rise;
  logic       pin_fall;
  logic       src_tick;
  logic       count_step;
  logic       ovf_now;
  logic       match_now;
  logic [7:0] cnt_next;
  logic       edge_evt;
  logic       wr_access;
  logic       rd_setup;
  logic       addr_hit;
  logic       wr_mode;
  logic       wr_flags;
  logic       wr_live;
  logic       sw_load;

  // Tap mask for division 2^n: all low n prescaler bits high
  function automatic logic [6:0] tap_mask(input logic [2:0] sel);
    logic [7:0] m;
    m = (8'h01 << sel) - 8'h01;
    return m[6:0];
  endfunction

  // True when the word address hits the given register index
  function automatic logic is_reg(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
    return (addr[ADDR_W-1:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // Read view of one register; write-only load bit reads zero
  function automatic logic [31:0] read_word(input timer_s s, input logic [ADDR_W-1:0] addr);
    logic [7:0] v;
    v = 8'h00;
    if (is_reg(addr, IDX_MODE_CONTROL))
    begin
      v = {1'b0, s.count_enable_bit, s.pwm_output_enable, s.edge_irq_enable,
           s.match_irq_enable, s.overflow_irq_enable, s.mode};
    end
    else if (is_reg(addr, IDX_FLAG_STATUS))
    begin
      v = {5'h00, s.edge_event_flag, s.match_flag, s.overflow_flag};
    end
    else if (is_reg(addr, IDX_CLOCK_EDGE))
    begin
      v = {s.prescale_select, 1'b0, s.edge_polarity_select, s.edge_detect_enable,
           s.clock_select};
    end
    else if (is_reg(addr, IDX_RELOAD_CAPT))
    begin
      v = s.reload_capture;
    end
    else if (is_reg(addr, IDX_COMPARE))
    begin
      v = s.compare_value;
    end
    else if (is_reg(addr, IDX_LIVE_LOAD))
    begin
      v = s.counter_value;
    end
    return {24'h00_0000, v};
  endfunction

  tick_div3 u_div3
  (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .tick_o    (div3_tick)
  );

  pin_edge_detect u_edge
  (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .pin_i     (timer_input_pin_i),
    .rise_o    (pin_rise),
    .fall_o    (pin_fall)
  );

  // Clock source mux; reserved code gives no ticks
  always_comb
  begin
    case (q.clock_select)
      CLK_INTERNAL: src_tick = 1'b1;
      CLK_DIV3:     src_tick = div3_tick;
      CLK_PIN:      src_tick = pin_rise;
      default:      src_tick = 1'b0;
    endcase
  end

  // Counter step on the selected prescaler tap
  assign count_step = q.count_enable_bit & src_tick &
                      ((q.prescaler & tap_mask(q.prescale_select)) == tap_mask(q.prescale_select));
  assign ovf_now    = count_step & (q.counter_value == CNT_MAX);
  // Only auto-reload reloads; other modes wrap to zero and run free
  assign cnt_next   = !ovf_now ? q.counter_value + 8'h01 :
                      (q.mode == MODE_AUTO_RELOAD) ? q.reload_capture : 8'h00;
  assign match_now  = count_step & (cnt_next == q.compare_value);

  // Edge select: disabled unless enable bit set, polarity picks edge
  assign edge_evt   = q.edge_detect_enable & (q.edge_polarity_select ? pin_fall : pin_rise);

  // APB decode
  assign addr_hit   = is_reg(paddr_i, IDX_MODE_CONTROL) | is_reg(paddr_i, IDX_FLAG_STATUS) |
                      is_reg(paddr_i, IDX_CLOCK_EDGE) | is_reg(paddr_i, IDX_RELOAD_CAPT) |
                      is_reg(paddr_i, IDX_COMPARE) | is_reg(paddr_i, IDX_LIVE_LOAD);
  assign wr_access  = psel_i & penable_i & pwrite_i;
  assign rd_setup   = psel_i & ~penable_i & ~pwrite_i;
  assign wr_mode    = wr_access & is_reg(paddr_i, IDX_MODE_CONTROL);
  assign wr_flags   = wr_access & is_reg(paddr_i, IDX_FLAG_STATUS);
  assign wr_live    = wr_access & is_reg(paddr_i, IDX_LIVE_LOAD);
  assign sw_load    = (wr_mode & pwdata_i[MC_LOAD_BIT]) | wr_live;

  // Next state: bus writes, then hardware events, then software loads
  always_comb
  begin
    d = q;
    // Plain register writes and flag clears; hardware sets below win
    if (wr_mode)
    begin
      d.count_enable_bit    = pwdata_i[MC_COUNT_EN];
      d.pwm_output_enable   = pwdata_i[MC_PWM_OE];
      d.edge_irq_enable     = pwdata_i[MC_EDGE_IE];
      d.match_irq_enable    = pwdata_i[MC_MATCH_IE];
      d.overflow_irq_enable = pwdata_i[MC_OVF_IE];
      d.mode                = mode_e'(pwdata_i[MC_MODE_LSB +: 2]);
    end
    if (wr_flags)
    begin
      d.edge_event_flag = q.edge_event_flag & pwdata_i[FS_EDGE];
      d.match_flag      = q.match_flag & pwdata_i[FS_MATCH];
      d.overflow_flag   = q.overflow_flag & pwdata_i[FS_OVF];
    end
    if (wr_access && is_reg(paddr_i, IDX_CLOCK_EDGE))
    begin
      d.prescale_select      = pwdata_i[CE_PS_LSB +: 3];
      d.edge_polarity_select = pwdata_i[CE_EDGE_POL];
      d.edge_detect_enable   = pwdata_i[CE_EDGE_EN];
      d.clock_select         = pwdata_i[CE_CLKSEL_LSB +: 2];
    end
    if (wr_access && is_reg(paddr_i, IDX_RELOAD_CAPT))
    begin
      d.reload_capture = pwdata_i[7:0];
    end
    if (wr_access && is_reg(paddr_i, IDX_COMPARE))
    begin
      d.compare_value = pwdata_i[7:0];
    end
    // Prescaler runs only while enabled, frozen otherwise
    if (q.count_enable_bit && src_tick)
    begin
      d.prescaler = q.prescaler + 7'h01;
    end
    if (count_step)
    begin
      d.counter_value = cnt_next;
    end
    if (ovf_now)
    begin
      d.overflow_flag = 1'b1;
      d.pwm_level     = 1'b1;
      if (q.mode == MODE_AUTO_RELOAD)
      begin
        d.prescaler = PRESC_RESET;
      end
    end
    // Match after overflow so a coincident match leaves the output low
    if (match_now)
    begin
      d.match_flag = 1'b1;
      d.pwm_level  = 1'b0;
    end
    if (edge_evt)
    begin
      d.edge_event_flag = 1'b1;
      case (q.mode)
        MODE_CAPTURE:
        begin
          d.reload_capture = q.counter_value;
        end
        MODE_CAPTURE_RESET:
        begin
          d.reload_capture = q.counter_value;
          d.counter_value  = CNT_RESET;
          d.prescaler      = PRESC_RESET;
        end
        MODE_EXT_LOAD:
        begin
          d.counter_value = q.reload_capture;
          d.prescaler     = PRESC_RESET;
        end
        default:
        begin
          d.counter_value = d.counter_value;
        end
      endcase
    end
    // Software loads win over counting so the written value is never lost
    if (wr_mode && pwdata_i[MC_LOAD_BIT])
    begin
      d.counter_value = q.reload_capture;
      d.prescaler     = PRESC_RESET;
    end
    if (wr_live)
    begin
      d.counter_value = pwdata_i[7:0];
      d.prescaler     = PRESC_RESET;
    end
    // Outputs registered from the next state
    d.pwm_pin   = d.pwm_level & d.pwm_output_enable;
    // Flags are sticky, so a request stays pending until serviced
    d.irq_ovf   = d.overflow_flag & d.overflow_irq_enable;
    d.irq_match = d.match_flag & d.match_irq_enable;
    d.irq_edge  = d.edge_event_flag & d.edge_irq_enable;
    if (rd_setup)
    begin
      d.prdata = read_word(q, paddr_i);
    end
  end

  // State register; reset stops counting and quiets the pin
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      q                <= '0;
      q.counter_value  <= CNT_RESET;
      q.prescaler      <= PRESC_RESET;
      q.reload_capture <= RELOAD_RESET;
      q.compare_value  <= COMPARE_RESET;
      q.prdata         <= RDATA_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // Zero-wait slave; read data captured in setup phase
  assign pready_o         = 1'b1;
  assign pslverr_o        = psel_i & penable_i & ~addr_hit;
  assign prdata_o         = q.prdata;
  assign pwm_output_pin_o = q.pwm_pin;
  assign irq_overflow_o   = q.irq_ovf;
  assign irq_match_o      = q.irq_match;
  assign irq_edge_o       = q.irq_edge;

  // Checks on the timer behaviour
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_overflow;
    ovf_now && !sw_load;
  endsequence
  sequence s_clear_ovf;
    wr_flags && !pwdata_i[FS_OVF];
  endsequence

  a_ovf_reload: assert property (s_overflow and (q.mode == MODE_AUTO_RELOAD) && !edge_evt
    |=> q.counter_value == $past(q.reload_capture) && q.prescaler == PRESC_RESET)
    else $error("overflow did not reload counter");
  a_ovf_output: assert property (ovf_now && !match_now |=> q.pwm_level)
    else $error("overflow did not raise output");
  a_match_low: assert property (match_now |=> !q.pwm_level && q.match_flag)
    else $error("match did not drop output");
  a_ovf_flag: assert property (ovf_now |=> q.overflow_flag && (q.irq_ovf == q.overflow_irq_enable))
    else $error("overflow flag or request wrong");
  a_ovf_sticky: assert property (q.overflow_flag && !(wr_flags && !pwdata_i[FS_OVF]) |=> q.overflow_flag)
    else $error("overflow flag lost without clear");
  a_load_bit: assert property (wr_mode && pwdata_i[MC_LOAD_BIT]
    |=> q.counter_value == $past(q.reload_capture))
    else $error("load bit did not copy reload");
  a_capture_copy: assert property (edge_evt && (q.mode == MODE_CAPTURE)
    |=> q.reload_capture == $past(q.counter_value) && q.edge_event_flag)
    else $error("capture did not copy counter");
  a_capture_reset: assert property (edge_evt && (q.mode == MODE_CAPTURE_RESET) && !sw_load
    |=> q.counter_value == CNT_RESET && q.prescaler == PRESC_RESET)
    else $error("capture did not clear counter");
  a_ext_load: assert property (edge_evt && (q.mode == MODE_EXT_LOAD) && !sw_load
    |=> q.counter_value == $past(q.reload_capture))
    else $error("external edge did not load counter");
  a_load_presc: assert property (sw_load |=> q.prescaler == PRESC_RESET)
    else $error("load did not clear prescaler");
  a_flag_keep: assert property (wr_flags && pwdata_i[2:0] == 3'h6 && q.edge_event_flag
    |=> q.edge_event_flag)
    else $error("edge flag lost on overflow clear");
  a_flag_clear: assert property (s_clear_ovf and !ovf_now |=> !q.overflow_flag)
    else $error("zero write did not clear flag");
  a_pwm_gate: assert property (pwm_output_pin_o |-> q.pwm_output_enable && q.pwm_level)
    else $error("output active while disabled");
  a_frozen: assert property (!q.count_enable_bit && !sw_load && !edge_evt
    |=> $stable(q.counter_value) && $stable(q.prescaler))
    else $error("counter moved while stopped");

endmodule // auto_reload_pwm_timer

// File: shared/timer_pkg.sv
// Register map, field layout and reset values of the auto-reload timer
package timer_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [9:0] IDX_MODE_CONTROL = 10'h0d5;
  localparam logic [9:0] IDX_FLAG_STATUS  = 10'h0d6;
  localparam logic [9:0] IDX_CLOCK_EDGE   = 10'h0d7;
  localparam logic [9:0] IDX_RELOAD_CAPT  = 10'h0d9;
  localparam logic [9:0] IDX_COMPARE      = 10'h0da;
  localparam logic [9:0] IDX_LIVE_LOAD    = 10'h0db;

  // APB widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  // Mode control fields
  localparam int unsigned MC_LOAD_BIT  = 7;
  localparam int unsigned MC_COUNT_EN  = 6;
  localparam int unsigned MC_PWM_OE    = 5;
  localparam int unsigned MC_EDGE_IE   = 4;
  localparam int unsigned MC_MATCH_IE  = 3;
  localparam int unsigned MC_OVF_IE    = 2;
  localparam int unsigned MC_MODE_LSB  = 0;

  // Flag status fields
  localparam int unsigned FS_EDGE  = 2;
  localparam int unsigned FS_MATCH = 1;
  localparam int unsigned FS_OVF   = 0;

  // Clock and edge configuration fields
  localparam int unsigned CE_PS_LSB     = 5;
  localparam int unsigned CE_EDGE_POL   = 3;
  localparam int unsigned CE_EDGE_EN    = 2;
  localparam int unsigned CE_CLKSEL_LSB = 0;

  // Clock source codes
  localparam logic [1:0] CLK_INTERNAL = 2'h0;
  localparam logic [1:0] CLK_DIV3     = 2'h1;
  localparam logic [1:0] CLK_PIN      = 2'h2;

  // Counter limits and reset values
  localparam logic [7:0]  CNT_MAX       = 8'hff;
  localparam logic [7:0]  CNT_RESET     = 8'h00;
  localparam logic [6:0]  PRESC_RESET   = 7'h00;
  localparam logic [7:0]  RELOAD_RESET  = 8'h00;
  localparam logic [7:0]  COMPARE_RESET = 8'h00;
  localparam logic [1:0]  DIV3_LAST     = 2'h2;
  localparam logic [31:0] RDATA_RESET   = 32'h0000_0000;

  // Operating modes in encoding order
  typedef enum logic [1:0] {
    MODE_AUTO_RELOAD,
    MODE_CAPTURE,
    MODE_CAPTURE_RESET,
    MODE_EXT_LOAD
  } mode_e;

endpackage

// File: hw/tick_div3.sv
// Pulse generator giving one tick every third clock cycle
`timescale 1ns/1ps
module tick_div3
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  // Tick out
  output logic      tick_o
);
  import timer_pkg::*;

  typedef struct packed {
    logic [1:0] cnt;
    logic       tick;
  } div_s;

  div_s q;
  div_s d;

  // Count 0..2, tick registered on the wrap
  always_comb
  begin
    d = q;
    d.tick = (q.cnt == DIV3_LAST);
    if (q.cnt == DIV3_LAST)
    begin
      d.cnt = 2'h0;
    end
    else
    begin
      d.cnt = q.cnt + 2'h1;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign tick_o = q.tick;
endmodule // tick_div3

// File: hw/pin_edge_detect.sv
// Rising and falling edge pulses of the timer input pin
`timescale 1ns/1ps
module pin_edge_detect
(
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  // Pin and edges
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  import timer_pkg::*;

  typedef struct packed {
    logic prev;
  } edge_s;

  edge_s q;
  edge_s d;

  // Pin is synchronous already, one history flop is enough
  always_comb
  begin
    d = q;
    d.prev = pin_i;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rise_o = pin_i & ~q.prev;
  assign fall_o = ~pin_i & q.prev;
endmodule // pin_edge_detect

// File: tb/timer_pin_partner.sv
// Pin-side model: edge source on the timer input, pulse meter on the PWM output
`timescale 1ns/1ps
module timer_pin_partner
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  // Edge source
  input  wire logic        go_i,
  input  wire logic        fall_i,
  input  wire logic [7:0]  gap_i,
  output logic             busy_o,
  output logic             pin_o,
  // PWM meter
  input  wire logic        pwm_i,
  output logic      [15:0] high_o,
  output logic      [15:0] period_o
);
  logic [7:0]  cnt_q;
  logic        prev_q;
  logic [15:0] run_q;

  // Busy until the last active pulse has gone back to idle
  assign busy_o = (cnt_q != 8'h00) || (pin_o != fall_i);

  // Two one-cycle active pulses, gap cycles apart; idle level set by polarity
  always @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      cnt_q <= 8'h00;
      pin_o <= 1'b0;
    end
    else
    begin
      pin_o <= fall_i ^ (go_i || (cnt_q == gap_i && cnt_q != 8'h00));
      if (go_i)
        cnt_q <= 8'h01;
      else if (cnt_q != 8'h00 && cnt_q < gap_i)
        cnt_q <= cnt_q + 8'h01;
      else
        cnt_q <= 8'h00;
    end
  end

  // High time and period in clock cycles; first period after reset is junk
  always @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      prev_q   <= 1'b0;
      run_q    <= 16'h0000;
      high_o   <= 16'h0000;
      period_o <= 16'h0000;
    end
    else
    begin
      prev_q <= pwm_i;
      run_q  <= (pwm_i && !prev_q) ? 16'h0001 : run_q + 16'h0001;
      if (pwm_i && !prev_q) period_o <= run_q;
      if (!pwm_i && prev_q) high_o <= run_q;
    end
  end
endmodule // timer_pin_partner

// File: tb/auto_reload_pwm_timer_modes_tb.sv
// Self-checking bench of the auto-reload timer over APB and its pins
`timescale 1ns/1ps
module auto_reload_pwm_timer_modes_tb;
  import timer_pkg::*;
  localparam logic [9:0] REGS [6] = '{IDX_MODE_CONTROL, IDX_FLAG_STATUS, IDX_CLOCK_EDGE,
                                      IDX_RELOAD_CAPT, IDX_COMPARE, IDX_LIVE_LOAD};
  logic        clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic        pin, pwm, irq_ov, irq_m, irq_e, go, fall, busy, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [7:0]  gap;
  logic [15:0] high, period;
  int          seed, bad_count, samples_checked, r, c, n, src, ie, m, v, flags_m;

  auto_reload_pwm_timer auto_reload_pwm_timer_inst (.ref_clk_i(clk), .rstn_i(rstn), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .timer_input_pin_i(pin), .pwm_output_pin_o(pwm),
    .irq_overflow_o(irq_ov), .irq_match_o(irq_m), .irq_edge_o(irq_e));
  timer_pin_partner timer_pin_partner_inst (.ref_clk_i(clk), .rstn_i(rstn), .go_i(go), .fall_i(fall),
    .gap_i(gap), .busy_o(busy), .pin_o(pin), .pwm_i(pwm), .high_o(high), .period_o(period));

  // 20 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, entered just after a rising edge; ends one idle edge later
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0000_00, wd};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20)
    begin
      bad_count++;
      conclude();
    end
    @(posedge clk);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] val);
    apb(1'b1, idx, val, rdv, err);
    // Flag model: a zero bit clears, a one bit keeps
    if (idx == IDX_FLAG_STATUS) flags_m = flags_m & int'(val);
  endtask

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00, rdv, err);
    chk(rdv, exp);
  endtask

  // Two active edges on the input pin, gap cycles apart
  task automatic pulse(input logic [7:0] g);
    int k;
    gap <= g;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (busy && k < 300);
    if (k >= 300)
    begin
      bad_count++;
      conclude();
    end
  endtask

  // Bounded wait for PWM rising edges
  task automatic wait_rise(input int cnt);
    int k;
    logic p;
    p = pwm;
    k = 0;
    while (cnt > 0 && k < 20000)
    begin
      @(posedge clk);
      k++;
      if (pwm && !p) cnt--;
      p = pwm;
    end
    if (k >= 20000)
    begin
      bad_count++;
      conclude();
    end
  endtask

  // Main sequence
  initial
  begin
    seed = 80;
    bad_count = 0;
    samples_checked = 0;
    flags_m = 0;
    {rstn, psel, penable, pwrite, go, fall} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    gap = 8'h02;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (REGS[i]) rd(REGS[i], 32'h0000_0000);
    chk({28'h0, pwm, irq_ov, irq_m, irq_e}, 32'h0000_0000);
    rd(10'h0d8, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    // Auto-reload PWM with random reload, compare, source and prescale
    r = {$random(seed)} % 200;
    c = r + 1 + {$random(seed)} % (255 - r);
    n = {$random(seed)} % 3;
    src = {$random(seed)} % 2;
    ie = {$random(seed)} % 4;
    m = (src == 1 ? 3 : 1) << n;
    wr(IDX_CLOCK_EDGE, 8'((n << CE_PS_LSB) | src));
    wr(IDX_RELOAD_CAPT, 8'(r));
    wr(IDX_COMPARE, 8'(c));
    wr(IDX_MODE_CONTROL, 8'(32'he0 | (ie << MC_OVF_IE)));
    rd(IDX_MODE_CONTROL, 32'h60 | (ie << MC_OVF_IE));
    wait_rise(2);
    flags_m = flags_m | 32'h0000_0003;
    rd(IDX_FLAG_STATUS, flags_m);
    chk({16'h0, high}, (c - r) * m);
    chk({16'h0, period}, (256 - r) * m);
    chk({30'h0, irq_m, irq_ov}, ie);
    // Stop before touching the clock setup; output and requests drop
    wr(IDX_MODE_CONTROL, 8'h00);
    chk({29'h0, pwm, irq_ov, irq_m}, 32'h0000_0000);
    // Capture mode, slow prescale so the live-loaded value is what is caught
    v = {$random(seed)} % 256;
    wr(IDX_CLOCK_EDGE, 8'he4);
    wr(IDX_LIVE_LOAD, 8'(v));
    wr(IDX_MODE_CONTROL, 8'h41);
    pulse(8'h02);
    rd(IDX_RELOAD_CAPT, v);
    flags_m = flags_m | 32'h0000_0004;
    // Capture with reset measures edge spacing
    wr(IDX_MODE_CONTROL, 8'h00);
    wr(IDX_COMPARE, 8'hff);
    wr(IDX_CLOCK_EDGE, 8'h04);
    wr(IDX_MODE_CONTROL, 8'h52);
    v = 5 + {$random(seed)} % 60;
    pulse(8'(v));
    rd(IDX_RELOAD_CAPT, v - 1);
    chk({31'h0, irq_e}, 32'h0000_0001);
    wr(IDX_MODE_CONTROL, 8'h00);
    rd(IDX_FLAG_STATUS, flags_m);
    // Flag clears: 06h drops only overflow, zeros drop the rest
    wr(IDX_FLAG_STATUS, 8'h06);
    rd(IDX_FLAG_STATUS, flags_m);
    wr(IDX_FLAG_STATUS, 8'h00);
    rd(IDX_FLAG_STATUS, flags_m);
    // Pin as count clock; edge detect off, so pin edges raise no edge flag
    v = {$random(seed)} % 250;
    wr(IDX_CLOCK_EDGE, 8'h02);
    wr(IDX_LIVE_LOAD, 8'(v));
    wr(IDX_MODE_CONTROL, 8'h40);
    pulse(8'h03);
    wr(IDX_MODE_CONTROL, 8'h00);
    rd(IDX_LIVE_LOAD, v + 2);
    rd(IDX_FLAG_STATUS, flags_m);
    // External load on falling edge while stopped; idle-high switch seen with detect off
    fall <= 1'b1;
    wr(IDX_CLOCK_EDGE, 8'h0c);
    v = {$random(seed)} % 256;
    wr(IDX_RELOAD_CAPT, 8'(v));
    wr(IDX_MODE_CONTROL, 8'h03);
    pulse(8'h02);
    rd(IDX_LIVE_LOAD, v);
    conclude();
  end
endmodule // auto_reload_pwm_timer_modes_tb
